/* bench/return_and_rotate_exec_test.sv */
// Self-checking testbench for the return and rotate execution unit.
`timescale 1ns/100ps
`default_nettype none
module return_and_rotate_exec_test;
   import rre_pkg::*;
   logic clk_sys, sys_rst, instrValid, extEnable;
   logic [15:0] instrWord;
   logic [20:0] stack_top_value;
   rre_ctx_t shadowCtx;
   logic [7:0] fileRdData, pc_upper_latch, pc_high_latch;
   logic [11:0] indexBase;
   logic [20:0] pcOut;
   logic pcLoad, stackPop, flushFetch, busy;
   rre_ctx_t ctxOut;
   rre_file_t fileReq;
   logic [7:0] fileAddrLow;
   // Bench copy of the working context, built only from the instruction rules.
   rre_ctx_t expCtx;
   // Last read and write requests seen, with a count of write pulses.
   rre_file_t rdReq, wrReq;
   int wrCnt, mismatches, n_tests, cycles;

   rre_exec i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .instrWord(instrWord),
      .instrValid(instrValid), .extEnable(extEnable), .stack_top_value(stack_top_value),
      .shadowCtx(shadowCtx), .fileRdData(fileRdData), .indexBase(indexBase),
      .pc_upper_latch(pc_upper_latch), .pc_high_latch(pc_high_latch), .pcOut(pcOut),
      .pcLoad(pcLoad), .stackPop(stackPop), .flushFetch(flushFetch), .ctxOut(ctxOut),
      .fileReq(fileReq), .fileAddrLow(fileAddrLow), .busy(busy));

   // The 100 ns system clock.
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   // Records file requests; a one-clock pulse is caught since it is sampled every edge.
   always @(posedge clk_sys) begin
      if (fileReq.valid === 1'b1) begin
         if (fileReq.write === 1'b1) begin
            wrReq = fileReq;
            wrCnt++;
         end else begin
            rdReq = fileReq;
         end
      end
   end

   // Cuts a hang short; the whole sequence needs well under 300 cycles.
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 2000) begin
         mismatches++;
         conclude();
      end
   end

   // Compares one value with its expectation, with four-state equality.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Issues one word at a Q1 edge and walks twelve clocks, so the next call lands on Q1.
   // With useExtra set, a second word is driven from Q2 on, but instrValid drops before the flush cycle's Q1 edge.
   task automatic run(input logic [15:0] word, input logic [15:0] extra,
                      input logic useExtra, input logic isRet);
      instrWord = word;
      instrValid = 1'b1;
      @(posedge clk_sys);
      #10;
      wrCnt = 0;
      if (useExtra) begin
         instrWord = extra;
      end else begin
         instrValid = 1'b0;
      end
      repeat (3) @(posedge clk_sys);
      #10;
      instrValid = 1'b0;
      check(stackPop, isRet);
      check(pcLoad, isRet);
      check(flushFetch, isRet);
      check(busy, isRet);
      repeat (3) @(posedge clk_sys);
      #10;
      check(flushFetch, isRet);
      check(stackPop, 1'b0);
      repeat (5) @(posedge clk_sys);
      #10;
      check(flushFetch, 1'b0);
   endtask

   // Runs one rotate and checks result, flags, destination and resolved address.
   task automatic rot(input logic d, input logic a, input logic ext, input logic [7:0] f,
                      input logic [7:0] op, input logic [11:0] expAddr, input logic expIdx);
      logic [7:0] r;
      r = {op[6:0], expCtx.flags[RRE_FLAG_C]};
      extEnable = ext;
      fileRdData = op;
      run({6'h0d, d, a, f}, 16'h0000, 1'b0, 1'b0);
      expCtx.flags[RRE_FLAG_C] = op[7];
      expCtx.flags[RRE_FLAG_Z] = (r == 8'h00);
      expCtx.flags[RRE_FLAG_N] = r[7];
      if (!d) begin
         expCtx.work = r;
      end
      check(ctxOut, expCtx);
      check(fileAddrLow, f);
      check(rdReq.addr, expAddr);
      check(rdReq.indexed, expIdx);
      check(wrCnt, d);
      if (d) begin
         check(wrReq.data, r);
         check(wrReq.addr, expAddr);
      end
   endtask

   // Main sequence.
   initial begin
      sys_rst = 1'b1;
      instrValid = 1'b0;
      extEnable = 1'b0;
      instrWord = 16'h0000;
      stack_top_value = 21'h000000;
      shadowCtx = '0;
      fileRdData = 8'h00;
      indexBase = 12'h123;
      pc_upper_latch = 8'h12;
      pc_high_latch = 8'h34;
      mismatches = 0;
      n_tests = 0;
      cycles = 0;
      wrCnt = 0;
      expCtx = '0;
      repeat (16) @(posedge clk_sys);
      #10;
      sys_rst = 1'b0;
      check(ctxOut, 32'h0);
      check(pcOut, 32'h0);
      // Fast return restores the shadow context; C set and stray flag bits 3 and 5.
      shadowCtx = '{work: 8'h5a, flags: 8'h29, bank: 4'h3};
      stack_top_value = 21'h01234a;
      run(16'h0013, 16'h0000, 1'b0, 1'b1);
      expCtx = shadowCtx;
      check(ctxOut, expCtx);
      check(pcOut, 21'h01234a);
      // Plain return must ignore a different shadow context.
      shadowCtx = '{work: 8'ha5, flags: 8'h10, bank: 4'hc};
      stack_top_value = 21'h1ffffe;
      run(16'h0012, 16'h0000, 1'b0, 1'b1);
      check(ctxOut, expCtx);
      check(pcOut, 21'h1ffffe);
      // Literal return at the top literal; a rotate word still on instrWord at the flush cycle's Q1 is dropped.
      stack_top_value = 21'h000100;
      fileRdData = 8'h81;
      run(16'h0cff, 16'h3420, 1'b1, 1'b1);
      expCtx.work = 8'hff;
      check(ctxOut, expCtx);
      check(pcOut, 21'h000100);
      check(wrCnt, 0);
      // Rotates: every destination, access and extended-mode corner of the address map.
      rot(1'b0, 1'b0, 1'b0, 8'h20, 8'h80, 12'h020, 1'b0);
      rot(1'b1, 1'b1, 1'b0, 8'h7f, 8'he6, 12'h37f, 1'b0);
      rot(1'b1, 1'b0, 1'b0, 8'h60, 8'h00, 12'hf60, 1'b0);
      rot(1'b1, 1'b0, 1'b1, 8'h5f, 8'h80, 12'h182, 1'b1);
      rot(1'b0, 1'b0, 1'b1, 8'h60, 8'h00, 12'hf60, 1'b0);
      rot(1'b0, 1'b1, 1'b1, 8'h05, 8'h7f, 12'h305, 1'b0);
      rot(1'b0, 1'b0, 1'b1, 8'h00, 8'h40, 12'h123, 1'b1);
      // The carry chain must keep the last rotate's flags across a return.
      run(16'h0012, 16'h0000, 1'b0, 1'b1);
      check(ctxOut, expCtx);
      conclude();
   end
endmodule
`default_nettype wire

/* hdl/rre_addr_sel.sv */
// File address resolver: access bank, banked space and indexed literal-offset mode.
`timescale 1ns/100ps
`default_nettype none
module rre_addr_sel
   import rre_pkg::*;
(
   input wire logic [7:0] fAddr,
   input wire logic accessSel,
   input wire logic extEnable,
   input wire logic [3:0] bankSel,
   input wire logic [11:0] indexBase,
   output logic [11:0] fullAddr,
   output logic indexed
);
   // Access bank: low part maps to bank zero, upper part to special registers.
   wire logic accLow = (fAddr < RRE_ACC_SPLIT);
   wire logic [11:0] accAddr = accLow ? {4'h0, fAddr} : {RRE_SFR_BANK, fAddr};
   // Indexed mode only with extended set, access bank and offset at most 95.
   assign indexed = extEnable && !accessSel && (fAddr <= RRE_IDX_LIMIT);
   wire logic [11:0] idxAddr = indexBase + {4'h0, fAddr};
   // Banked space uses the bank select register as the upper nibble.
   wire logic [11:0] bankAddr = {bankSel, fAddr};
   assign fullAddr = indexed ? idxAddr : (accessSel ? bankAddr : accAddr);
endmodule
`default_nettype wire

/* hdl/rre_exec.sv */
// Execution unit for return-literal, return-from-subroutine and rotate-left-through-carry.
`timescale 1ns/100ps
`default_nettype none
module rre_exec
   import rre_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [15:0] instrWord,
   input wire logic instrValid,
   input wire logic extEnable,
   input wire logic [20:0] stack_top_value,
   input wire rre_ctx_t shadowCtx,
   input wire logic [7:0] fileRdData,
   input wire logic [11:0] indexBase,
   input wire logic [7:0] pc_upper_latch,
   input wire logic [7:0] pc_high_latch,
   output logic [20:0] pcOut,
   output logic pcLoad,
   output logic stackPop,
   output logic flushFetch,
   output rre_ctx_t ctxOut,
   output rre_file_t fileReq,
   output logic [7:0] fileAddrLow,
   output logic busy
);
   // Instruction fields.
   wire logic [7:0] litK = instrWord[7:0];
   wire logic [7:0] fAddr = instrWord[7:0];
   wire logic destBit = instrWord[RRE_DEST_BIT];
   wire logic accBit = instrWord[RRE_ACC_BIT];
   wire logic fastBit = instrWord[RRE_FAST_BIT];

   // Opcode decoders; the return pattern ignores only its low flag bit.
   wire logic isRetLw = (instrWord[15:8] == RRE_RETURN_WITH_LITERAL_OP_HI);
   wire logic isReturn = (instrWord[15:1] == RRE_RETURN_PAT);
   wire logic isRlcf = (instrWord[15:10] == RRE_ROTATE_LEFT_CARRY_OP_HI);

   // Phase counter and state.
   rre_phase_t phase_r;
   rre_phase_t phase_nxt;
   rre_state_t state_r;
   rre_state_t state_nxt;
   // Latched instruction for the current cycle, captured at Q1.
   logic [15:0] held_r;
   logic heldValid_r;

   // Internal registers of the core context.
   rre_ctx_t ctx_r;
   rre_ctx_t ctx_nxt;
   logic [20:0] pc_r;
   logic [20:0] pc_nxt;
   logic pcLoad_r;
   logic stackPop_r;
   logic flush_r;
   rre_file_t fileReq_r;
   rre_file_t fileReq_nxt;
   logic [7:0] fileLow_r;

   // Decoded view of the held word.
   wire logic hRetLw = heldValid_r && (held_r[15:8] == RRE_RETURN_WITH_LITERAL_OP_HI);
   wire logic hReturn = heldValid_r && (held_r[15:1] == RRE_RETURN_PAT);
   wire logic hRlcf = heldValid_r && (held_r[15:10] == RRE_ROTATE_LEFT_CARRY_OP_HI);
   wire logic hFast = held_r[RRE_FAST_BIT];
   wire logic hDest = held_r[RRE_DEST_BIT];
   wire logic hAcc = held_r[RRE_ACC_BIT];
   wire logic isQ4 = (phase_r == RRE_Q4);
   wire logic isQ1 = (phase_r == RRE_Q1);

   // Address resolution for the rotate operand.
   logic [11:0] resAddr;
   logic resIndexed;
   rre_addr_sel u_addr (
      .fAddr(held_r[7:0]),
      .accessSel(hAcc),
      .extEnable(extEnable),
      .bankSel(ctx_r.bank),
      .indexBase(indexBase),
      .fullAddr(resAddr),
      .indexed(resIndexed)
   );

   // Rotate datapath on the file register data read in Q3.
   logic [7:0] rotRes;
   logic rotC;
   logic rotN;
   logic rotZ;
   rre_rotate u_rot (
      .operand(fileRdData),
      .carryIn(ctx_r.flags[RRE_FLAG_C]),
      .result(rotRes),
      .carryOut(rotC),
      .negOut(rotN),
      .zeroOut(rotZ)
   );

   // Phase advances every clock; four clocks make one instruction cycle.
   assign phase_nxt = rre_phase_t'(phase_r + 2'h1);

   // A return executed at Q4 moves to the flush cycle; the flush ends at its Q4.
   assign state_nxt = (isQ4 && state_r == RRE_EXEC && (hRetLw || hReturn)) ? RRE_FLUSH :
                      (isQ4 && state_r == RRE_FLUSH) ? RRE_EXEC : state_r;

   // The popped top of stack always lands in the PC; the latches are never read here.
   assign pc_nxt = (isQ4 && state_r == RRE_EXEC && (hRetLw || hReturn)) ? stack_top_value : pc_r;

   // Context update at Q4 of the executing cycle.
   always_comb begin
      ctx_nxt = ctx_r;
      if (isQ4 && state_r == RRE_EXEC) begin
         if (hRetLw) begin
            // Only the work register changes; flags stay intact.
            ctx_nxt.work = held_r[7:0];
         end else if (hReturn && hFast) begin
            // Fast return restores the shadow copies as one set.
            ctx_nxt = shadowCtx;
         end else if (hReturn) begin
            // Plain return leaves work, flags and bank as they are.
            ctx_nxt = ctx_r;
         end else if (hRlcf) begin
            ctx_nxt.flags[RRE_FLAG_C] = rotC;
            ctx_nxt.flags[RRE_FLAG_N] = rotN;
            ctx_nxt.flags[RRE_FLAG_Z] = rotZ;
            if (!hDest) begin
               ctx_nxt.work = rotRes;
            end
         end
      end
   end

   // File port: read strobe in Q3, write back in Q4 when the destination is the file.
   always_comb begin
      fileReq_nxt = '0;
      if (hRlcf && state_r == RRE_EXEC) begin
         fileReq_nxt.addr = resAddr;
         fileReq_nxt.indexed = resIndexed;
         // The held word is only valid after the Q1 edge, so the read pulse is built in Q2.
         if (phase_r == RRE_Q2) begin
            fileReq_nxt.valid = 1'b1;
         end else if (phase_r == RRE_Q3 && hDest) begin
            fileReq_nxt.valid = 1'b1;
            fileReq_nxt.write = 1'b1;
            fileReq_nxt.data = rotRes;
         end
      end
   end

   // Phase, state and instruction latch. The word is captured at every Q1 but marked valid only outside a flush,
   // so the prefetched word seen during the flush cycle is discarded.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         phase_r <= RRE_Q1;
         state_r <= RRE_EXEC;
         held_r <= 16'h0000;
         heldValid_r <= 1'b0;
      end else begin
         phase_r <= phase_nxt;
         state_r <= state_nxt;
         if (isQ1) begin
            held_r <= instrWord;
            heldValid_r <= instrValid && (state_r == RRE_EXEC);
         end
      end
   end

   // Architectural state and registered outputs.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         ctx_r <= '0;
         pc_r <= RRE_PC_RST;
         pcLoad_r <= 1'b0;
         stackPop_r <= 1'b0;
         flush_r <= 1'b0;
         fileReq_r <= '0;
         fileLow_r <= RRE_BYTE_RST;
      end else begin
         ctx_r <= ctx_nxt;
         pc_r <= pc_nxt;
         pcLoad_r <= isQ4 && state_r == RRE_EXEC && (hRetLw || hReturn);
         stackPop_r <= isQ4 && state_r == RRE_EXEC && (hRetLw || hReturn);
         flush_r <= (state_nxt == RRE_FLUSH);
         fileReq_r <= fileReq_nxt;
         fileLow_r <= held_r[7:0];
      end
   end

   assign pcOut = pc_r;
   assign pcLoad = pcLoad_r;
   assign stackPop = stackPop_r;
   assign flushFetch = flush_r;
   assign ctxOut = ctx_r;
   assign fileReq = fileReq_r;
   assign fileAddrLow = fileLow_r;
   assign busy = flush_r;

   // Unused decode of the raw input kept for cover only.
   wire logic rawRet = instrValid && (isRetLw || isReturn || isRlcf);

   // A return at Q4 loads the top of stack into the PC one clock later.
   a_return_pops_pc: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (isQ4 && state_r == RRE_EXEC && (hRetLw || hReturn))
      |=> (pcOut == $past(stack_top_value) && stackPop && pcLoad))
      else $error("Return did not pop the stack into the PC.");
   a_fast_restore: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (isQ4 && state_r == RRE_EXEC && hReturn && hFast) |=> (ctxOut == $past(shadowCtx)))
      else $error("Fast return did not restore the shadow context.");
   a_plain_keep: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (isQ4 && state_r == RRE_EXEC && hReturn && !hFast) |=> $stable(ctxOut))
      else $error("Plain return changed the context.");
   a_literal_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (isQ4 && state_r == RRE_EXEC && hRetLw)
      |=> (ctxOut.work == $past(held_r[7:0]) && $stable(ctxOut.flags)))
      else $error("Return-literal did not load the literal or touched flags.");
   a_rot_flags: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (isQ4 && state_r == RRE_EXEC && hRlcf)
      |=> (ctxOut.flags[RRE_FLAG_C] == $past(fileRdData[7])))
      else $error("Rotate carry is not the old bit 7.");
   a_rot_dest: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (phase_r == RRE_Q3 && state_r == RRE_EXEC && hRlcf && hDest)
      |=> (fileReq.write && fileReq.valid))
      else $error("Rotate with file destination did not write back.");
   a_bank_addr: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (phase_r == RRE_Q2 && state_r == RRE_EXEC && hRlcf && hAcc)
      |=> (fileReq.addr[11:8] == $past(ctx_r.bank)))
      else $error("Banked access ignored the bank select register.");
   a_flush_len: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (isQ4 && state_r == RRE_EXEC && (hRetLw || hReturn)) |=> flushFetch [*4] ##1 !flushFetch)
      else $error("Return flush cycle is not one instruction cycle long.");

   c_return_with_literal_op: cover property (@(posedge clk_sys) disable iff (sys_rst) isQ4 && hRetLw);
   c_fast: cover property (@(posedge clk_sys) disable iff (sys_rst) isQ4 && hReturn && hFast);
   c_rotate_left_carry_op_w: cover property (@(posedge clk_sys) disable iff (sys_rst) isQ4 && hRlcf && !hDest);
   c_indexed: cover property (@(posedge clk_sys) disable iff (sys_rst) fileReq.indexed);
   c_raw: cover property (@(posedge clk_sys) disable iff (sys_rst) rawRet);
endmodule
`default_nettype wire

/* hdl/rre_pkg.sv */
// Package of encodings, field positions, reset values and carrier types for the return/rotate unit.
package rre_pkg;
   // Opcode match patterns, upper byte or upper bits of the 16-bit word.
   localparam logic [7:0] RRE_RETURN_WITH_LITERAL_OP_HI = 8'h0c;
   localparam logic [14:0] RRE_RETURN_PAT = 15'h0009;
   localparam logic [5:0] RRE_ROTATE_LEFT_CARRY_OP_HI = 6'h0d;
   // Field positions inside the instruction word.
   localparam int RRE_DEST_BIT = 9;
   localparam int RRE_ACC_BIT = 8;
   localparam int RRE_FAST_BIT = 0;
   // Access bank split and indexed literal-offset limit.
   localparam logic [7:0] RRE_IDX_LIMIT = 8'h5f;
   localparam logic [7:0] RRE_ACC_SPLIT = 8'h60;
   localparam logic [3:0] RRE_SFR_BANK = 4'hf;
   // Flag bit positions within the flags register.
   localparam int RRE_FLAG_C = 0;
   localparam int RRE_FLAG_Z = 2;
   localparam int RRE_FLAG_N = 4;
   // Reset values.
   localparam logic [20:0] RRE_PC_RST = 21'h000000;
   localparam logic [7:0] RRE_BYTE_RST = 8'h00;
   // Index of the last quarter phase of one instruction cycle.
   localparam logic [1:0] RRE_PHASE_LAST = 2'h3;

   // Instruction cycle phase.
   typedef enum logic [1:0] {
      RRE_Q1 = 2'b00,
      RRE_Q2 = 2'b01,
      RRE_Q3 = 2'b10,
      RRE_Q4 = 2'b11
   } rre_phase_t;

   // Execution state: normal or flush cycle after a return.
   typedef enum logic [0:0] {
      RRE_EXEC = 1'b0,
      RRE_FLUSH = 1'b1
   } rre_state_t;

   // Core working context that the returns may restore.
   typedef struct packed {
      logic [7:0] work;
      logic [7:0] flags;
      logic [3:0] bank;
   } rre_ctx_t;

   // File register access request.
   typedef struct packed {
      logic valid;
      logic write;
      logic indexed;
      logic [11:0] addr;
      logic [7:0] data;
   } rre_file_t;
endpackage

/* hdl/rre_rotate.sv */
// Rotate-left-through-carry datapath with carry, negative and zero flag results.
`timescale 1ns/100ps
`default_nettype none
module rre_rotate
   import rre_pkg::*;
(
   input wire logic [7:0] operand,
   input wire logic carryIn,
   output logic [7:0] result,
   output logic carryOut,
   output logic negOut,
   output logic zeroOut
);
   // Each bit moves up one place, old carry enters at bit 0.
   assign result = {operand[6:0], carryIn};
   assign carryOut = operand[7];
   assign negOut = result[7];
   assign zeroOut = (result == 8'h00);
endmodule
`default_nettype wire
